//--- logic/sssel_top.sv
/*
  Servo stop-mode selection: AHB-Lite register slave, pin synchronisers,
  travel-inhibit handling, servo-off and supply-loss stop sequencing,
  undervoltage trip, gear numerator choice and encoder divider output.
  Assumes a single 40 MHz clock hclk, hresetn asynchronous active low,
  and asynchronous drive pins.
*/
// Operation
// RQ1: Inhibit select 1 ignores both inhibit inputs
// RQ2: Select 0 or 2 acts on inhibit inputs
// RQ3: Inhibit drops torque, then brake/free-run/estop
// RQ4: Settings 0-7: free-run, servo-free, counter-hold bits
// RQ5: Settings 8/9: estop, clear counter, brake/free
// RQ6: Supply loss stops by its own setting
// RQ7: Supply alarm trips undervoltage or servo off
// RQ8: Supply alarm only after hold time elapses
// RQ9: Divider denominator drives pulse regeneration
// RQ10: Three alternative gear numerators with denominator
// RQ11: All numerators zero substitutes encoder resolution
// RQ12: Frozen settings apply after power cycle
`timescale 1ns/100ps
`default_nettype none
`include "sssel_consts.svh"
module sssel_top import sssel_pkg::*; #(
  parameter int unsigned MS_CYCLES = `SSSEL_HOLD_STEP_NS / `SSSEL_CLK_PERIOD_NS,
  parameter logic [30:0] ENC_RESOLUTION = 31'h0002_0000
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire logic fwd_inhibit_in,
  input wire logic rev_inhibit_in,
  input wire logic servo_on_in,
  input wire logic main_power_ok_in,
  input wire logic motor_stopped_in,
  input wire logic [1:0] gear_select_in,
  output logic servo_enable,
  output logic fwd_torque_off,
  output logic rev_torque_off,
  output logic dyn_brake,
  output logic free_run,
  output logic emerg_stop,
  output logic servo_free,
  output logic err_clear,
  output logic err_hold,
  output logic undervoltage_alarm,
  output logic [30:0] gear_numerator,
  output logic [30:0] gear_denominator,
  output logic [18:0] encoder_divider_denominator,
  output logic irq
);
  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers
  logic [6:0] sync1_r, sync2_r;
  logic fwd_s, rev_s, servo_on_s, pwr_ok_s, stopped_s, pwr_ok_d_r, pw_on;
  logic [1:0] gear_sel_s;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sync1_r <= '0;
      sync2_r <= '0;
      pwr_ok_d_r <= 1'b0;
    end else begin
      sync1_r <= {gear_select_in, motor_stopped_in, main_power_ok_in, servo_on_in,
                  rev_inhibit_in, fwd_inhibit_in};
      sync2_r <= sync1_r;
      pwr_ok_d_r <= pwr_ok_s;
    end
  end

  assign {gear_sel_s, stopped_s, pwr_ok_s, servo_on_s, rev_s, fwd_s} = sync2_r;
  assign pw_on = pwr_ok_s & ~pwr_ok_d_r;

  ////////////////////////////////////////////////////////////////////////////
  // AHB-Lite slave: zero wait states, always OKAY
  logic take, wr_pend_r, wr_pend_nxt;
  logic [7:0] wr_addr_r, wr_addr_nxt;
  logic [31:0] hrdata_r, hrdata_nxt;

  assign take = hsel & htrans[1] & hready;
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign hrdata = hrdata_r;

  ////////////////////////////////////////////////////////////////////////////
  // Settings, frozen copies and interrupt registers
  logic [30:0] num_a_r, num_a_nxt, num_b_r, num_b_nxt, num_c_r, num_c_nxt, den_r, den_nxt;
  logic [18:0] div_r, div_nxt, act_div_r, act_div_nxt;
  logic [1:0] tsel_r, tsel_nxt, tstop_r, tstop_nxt;
  logic [1:0] act_tsel_r, act_tsel_nxt, act_tstop_r, act_tstop_nxt;
  logic [3:0] soff_r, soff_nxt, ploss_r, ploss_nxt;
  logic uv_sel_r, uv_sel_nxt;
  logic [10:0] hold_r, hold_nxt, act_hold_r, act_hold_nxt;
  logic [`SSSEL_IRQ_W-1:0] irq_st_r, irq_st_nxt, irq_en_r, irq_en_nxt, irq_clr;
  logic [`SSSEL_IRQ_W-1:0] ev_cur, ev_prev_r;
  sssel_state_t state_r, state_nxt;
  sssel_cause_t cause;
  logic uv_r, uv_nxt, power_alarm;

  always_comb begin
    num_a_nxt = num_a_r;
    num_b_nxt = num_b_r;
    num_c_nxt = num_c_r;
    den_nxt = den_r;
    div_nxt = div_r;
    tsel_nxt = tsel_r;
    tstop_nxt = tstop_r;
    soff_nxt = soff_r;
    ploss_nxt = ploss_r;
    uv_sel_nxt = uv_sel_r;
    hold_nxt = hold_r;
    irq_en_nxt = irq_en_r;
    irq_clr = '0;
    wr_pend_nxt = take & hwrite;
    wr_addr_nxt = take ? haddr[7:0] : wr_addr_r;
    if (wr_pend_r) begin
      case (wr_addr_r)
        `SSSEL_OFS_GEAR_NUM_A: if (hwdata <= `SSSEL_MAX_GEAR_NUM) num_a_nxt = hwdata[30:0];
        `SSSEL_OFS_GEAR_NUM_B: if (hwdata <= `SSSEL_MAX_GEAR_NUM) num_b_nxt = hwdata[30:0];
        `SSSEL_OFS_GEAR_NUM_C: if (hwdata <= `SSSEL_MAX_GEAR_NUM) num_c_nxt = hwdata[30:0];
        `SSSEL_OFS_GEAR_DEN: if (hwdata <= `SSSEL_MAX_GEAR_DEN) den_nxt = hwdata[30:0];
        `SSSEL_OFS_ENC_DIV: if (hwdata <= `SSSEL_MAX_ENC_DIV) div_nxt = hwdata[18:0];
        `SSSEL_OFS_TRAVEL_SEL: if (hwdata <= `SSSEL_MAX_TRAVEL) tsel_nxt = hwdata[1:0];
        `SSSEL_OFS_TRAVEL_STOP: if (hwdata <= `SSSEL_MAX_TRAVEL) tstop_nxt = hwdata[1:0];
        `SSSEL_OFS_SERVO_OFF_STOP: if (hwdata <= `SSSEL_MAX_STOP_SEL) soff_nxt = hwdata[3:0];
        `SSSEL_OFS_PWR_LOSS_STOP: if (hwdata <= `SSSEL_MAX_STOP_SEL) ploss_nxt = hwdata[3:0];
        `SSSEL_OFS_UV_SELECT: if (hwdata <= `SSSEL_MAX_UV_SELECT) uv_sel_nxt = hwdata[0];
        `SSSEL_OFS_HOLD_TIME: begin
          if (hwdata >= `SSSEL_MIN_HOLD_TIME && hwdata <= `SSSEL_MAX_HOLD_TIME) begin
            hold_nxt = hwdata[10:0];
          end
        end
        `SSSEL_OFS_IRQ_ENABLE: irq_en_nxt = hwdata[`SSSEL_IRQ_W-1:0];
        `SSSEL_OFS_IRQ_CLEAR: irq_clr = hwdata[`SSSEL_IRQ_W-1:0];
        default: ;
      endcase
    end
    // Frozen copies follow the settings only on a supply off-to-on edge
    act_div_nxt = pw_on ? div_r : act_div_r; // RQ12
    act_tsel_nxt = pw_on ? tsel_r : act_tsel_r; // RQ12
    act_tstop_nxt = pw_on ? tstop_r : act_tstop_r; // RQ12
    act_hold_nxt = pw_on ? hold_r : act_hold_r; // RQ12
    // A new event wins over a clear in the same cycle
    irq_st_nxt = (irq_st_r & ~irq_clr) | (ev_cur & ~ev_prev_r);
  end

  // Read data is sampled in the address phase and shown in the data phase
  always_comb begin
    hrdata_nxt = '0;
    if (take && !hwrite) begin
      case (haddr[7:0])
        `SSSEL_OFS_GEAR_NUM_A: hrdata_nxt = {1'b0, num_a_r};
        `SSSEL_OFS_GEAR_NUM_B: hrdata_nxt = {1'b0, num_b_r};
        `SSSEL_OFS_GEAR_NUM_C: hrdata_nxt = {1'b0, num_c_r};
        `SSSEL_OFS_GEAR_DEN: hrdata_nxt = {1'b0, den_r};
        `SSSEL_OFS_ENC_DIV: hrdata_nxt = {13'h0000, div_r};
        `SSSEL_OFS_TRAVEL_SEL: hrdata_nxt = {30'h0000_0000, tsel_r};
        `SSSEL_OFS_TRAVEL_STOP: hrdata_nxt = {30'h0000_0000, tstop_r};
        `SSSEL_OFS_SERVO_OFF_STOP: hrdata_nxt = {28'h000_0000, soff_r};
        `SSSEL_OFS_PWR_LOSS_STOP: hrdata_nxt = {28'h000_0000, ploss_r};
        `SSSEL_OFS_UV_SELECT: hrdata_nxt = {31'h0000_0000, uv_sel_r};
        `SSSEL_OFS_HOLD_TIME: hrdata_nxt = {21'h00_0000, hold_r};
        `SSSEL_OFS_STATUS: begin
          hrdata_nxt = {25'h000_0000, uv_r, power_alarm, servo_enable, cause, state_r};
        end
        `SSSEL_OFS_IRQ_STATUS: hrdata_nxt = {27'h000_0000, irq_st_r};
        `SSSEL_OFS_IRQ_ENABLE: hrdata_nxt = {27'h000_0000, irq_en_r};
        `SSSEL_OFS_ACTIVE_CFG: begin
          hrdata_nxt = {5'h00, act_hold_r, 10'h000, act_tstop_r, 2'h0, act_tsel_r};
        end
        `SSSEL_OFS_ACTIVE_DIV: hrdata_nxt = {13'h0000, act_div_r};
        default: ;
      endcase
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_r <= 1'b0;
      wr_addr_r <= 8'h00;
      hrdata_r <= 32'h0000_0000;
      num_a_r <= `SSSEL_RST_GEAR_NUM;
      num_b_r <= `SSSEL_RST_GEAR_NUM;
      num_c_r <= `SSSEL_RST_GEAR_NUM;
      den_r <= `SSSEL_RST_GEAR_DEN;
      div_r <= `SSSEL_RST_ENC_DIV;
      tsel_r <= `SSSEL_RST_TRAVEL_SEL;
      tstop_r <= `SSSEL_RST_TRAVEL_STOP;
      soff_r <= `SSSEL_RST_STOP_SEL;
      ploss_r <= `SSSEL_RST_STOP_SEL;
      uv_sel_r <= `SSSEL_RST_UV_SELECT;
      hold_r <= `SSSEL_RST_HOLD_TIME;
      act_div_r <= `SSSEL_RST_ENC_DIV;
      act_tsel_r <= `SSSEL_RST_TRAVEL_SEL;
      act_tstop_r <= `SSSEL_RST_TRAVEL_STOP;
      act_hold_r <= `SSSEL_RST_HOLD_TIME;
      irq_st_r <= '0;
      irq_en_r <= '0;
      ev_prev_r <= '0;
    end else begin
      wr_pend_r <= wr_pend_nxt;
      wr_addr_r <= wr_addr_nxt;
      hrdata_r <= hrdata_nxt;
      num_a_r <= num_a_nxt;
      num_b_r <= num_b_nxt;
      num_c_r <= num_c_nxt;
      den_r <= den_nxt;
      div_r <= div_nxt;
      tsel_r <= tsel_nxt;
      tstop_r <= tstop_nxt;
      soff_r <= soff_nxt;
      ploss_r <= ploss_nxt;
      uv_sel_r <= uv_sel_nxt;
      hold_r <= hold_nxt;
      act_div_r <= act_div_nxt;
      act_tsel_r <= act_tsel_nxt;
      act_tstop_r <= act_tstop_nxt;
      act_hold_r <= act_hold_nxt;
      irq_st_r <= irq_st_nxt;
      irq_en_r <= irq_en_nxt;
      ev_prev_r <= ev_cur;
    end
  end

  assign irq = |(irq_st_r & irq_en_r);

  ////////////////////////////////////////////////////////////////////////////
  // Supply-loss timer and stop decoders
  sssel_stop_if soff_if();
  sssel_stop_if ploss_if();
  assign soff_if.setting = soff_r;
  assign ploss_if.setting = ploss_r;

  sssel_stop_decode u_soff_dec (.stop(soff_if.dec));
  sssel_stop_decode u_ploss_dec (.stop(ploss_if.dec));

  sssel_hold_timer #(.MS_CYCLES(MS_CYCLES), .HOLD_W(11)) u_hold (
    .hclk(hclk),
    .hresetn(hresetn),
    .supply_lost(~pwr_ok_s),
    .hold_ms(act_hold_r),
    .alarm(power_alarm)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Stop sequencing and outputs
  logic inh_en, fwd_act, rev_act, en_nxt, fwd_off_nxt, rev_off_nxt;
  logic dyn_nxt, free_nxt, estop_nxt, sfree_nxt, clr_nxt, hold_cnt_nxt;
  sssel_decel_t sel_decel;
  sssel_after_t sel_after;
  logic sel_hold;
  logic [30:0] gnum_nxt;

  assign inh_en = act_tsel_r != `SSSEL_TRAVEL_IGNORE; // RQ1 RQ2
  assign fwd_act = inh_en & fwd_s;
  assign rev_act = inh_en & rev_s;
  assign ev_cur = {state_r == st_stopped, uv_r, power_alarm, rev_act, fwd_act};

  always_comb begin
    uv_nxt = uv_r | (power_alarm & uv_sel_r); // RQ7
    if (uv_r || power_alarm) begin
      cause = cause_power; // RQ6 RQ7
    end else if (!servo_on_s) begin
      cause = cause_servo_off;
    end else begin
      cause = cause_none;
    end
    sel_decel = (cause == cause_power) ? ploss_if.decel : soff_if.decel; // RQ6
    sel_after = (cause == cause_power) ? ploss_if.after : soff_if.after; // RQ6
    sel_hold = (cause == cause_power) ? ploss_if.hold_count : soff_if.hold_count;
    state_nxt = state_r;
    case (state_r)
      st_run: if (cause != cause_none) state_nxt = st_decel;
      st_decel: begin
        if (cause == cause_none) state_nxt = st_run;
        else if (stopped_s) state_nxt = st_stopped;
      end
      st_stopped: if (cause == cause_none) state_nxt = st_run;
      default: state_nxt = st_run;
    endcase
    fwd_off_nxt = fwd_act; // RQ2 RQ3
    rev_off_nxt = rev_act; // RQ2 RQ3
    en_nxt = 1'b0;
    dyn_nxt = 1'b0;
    free_nxt = 1'b0;
    estop_nxt = 1'b0;
    sfree_nxt = 1'b0;
    clr_nxt = 1'b0;
    hold_cnt_nxt = 1'b0;
    case (state_r)
      st_run: begin
        if (cause == cause_none) begin
          en_nxt = 1'b1;
          if (fwd_act || rev_act) begin
            case (act_tstop_r) // RQ3
              2'h0: dyn_nxt = 1'b1;
              `SSSEL_TSTOP_FREE: free_nxt = 1'b1;
              default: estop_nxt = 1'b1;
            endcase
          end
        end
      end
      st_decel: begin
        dyn_nxt = sel_decel == decel_dbrake; // RQ4 RQ5
        free_nxt = sel_decel == decel_free; // RQ4
        estop_nxt = sel_decel == decel_estop; // RQ5
        clr_nxt = ~sel_hold; // RQ4 RQ5
        hold_cnt_nxt = sel_hold; // RQ4
      end
      st_stopped: begin
        dyn_nxt = sel_after == after_dbrake; // RQ4 RQ5
        sfree_nxt = sel_after == after_free; // RQ4 RQ5
        clr_nxt = ~sel_hold;
        hold_cnt_nxt = sel_hold;
      end
      default: ;
    endcase
    // Alternative numerators, or the encoder resolution when all are zero
    if ((num_a_r | num_b_r | num_c_r) == 31'h0000_0000) begin
      gnum_nxt = ENC_RESOLUTION; // RQ11
    end else begin
      case (gear_sel_s) // RQ10
        2'h1: gnum_nxt = num_b_r;
        2'h2: gnum_nxt = num_c_r;
        default: gnum_nxt = num_a_r;
      endcase
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_r <= st_run;
      uv_r <= 1'b0;
      servo_enable <= 1'b0;
      fwd_torque_off <= 1'b0;
      rev_torque_off <= 1'b0;
      dyn_brake <= 1'b0;
      free_run <= 1'b0;
      emerg_stop <= 1'b0;
      servo_free <= 1'b0;
      err_clear <= 1'b0;
      err_hold <= 1'b0;
      gear_numerator <= 31'h0000_0000;
      gear_denominator <= `SSSEL_RST_GEAR_DEN;
    end else begin
      state_r <= state_nxt;
      uv_r <= uv_nxt;
      servo_enable <= en_nxt;
      fwd_torque_off <= fwd_off_nxt;
      rev_torque_off <= rev_off_nxt;
      dyn_brake <= dyn_nxt;
      free_run <= free_nxt;
      emerg_stop <= estop_nxt;
      servo_free <= sfree_nxt;
      err_clear <= clr_nxt;
      err_hold <= hold_cnt_nxt;
      gear_numerator <= gnum_nxt;
      gear_denominator <= den_r; // RQ10
    end
  end

  assign undervoltage_alarm = uv_r; // RQ7
  assign encoder_divider_denominator = act_div_r; // RQ9

  ////////////////////////////////////////////////////////////////////////////
  // Assertions
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  a_inhibit_ignored: assert property ( // RQ1
    act_tsel_r == `SSSEL_TRAVEL_IGNORE |=> !fwd_torque_off && !rev_torque_off)
    else $error("inhibit input acted on while ignored");
  a_inhibit_torque: assert property ( // RQ2
    act_tsel_r != `SSSEL_TRAVEL_IGNORE && fwd_s |=> fwd_torque_off)
    else $error("forward torque not removed");
  a_inhibit_estop: assert property ( // RQ3
    state_r == st_run && cause == cause_none && rev_act && act_tstop_r == 2'h2
    |=> emerg_stop && !dyn_brake && !free_run) else $error("inhibit stop mode wrong");
  a_servo_off_hold: assert property ( // RQ4
    state_r == st_decel && cause == cause_servo_off && soff_r inside {[4'h4:4'h7]}
    |=> err_hold && !err_clear) else $error("error counter not held");
  a_estop_clear: assert property ( // RQ5
    state_r == st_decel && cause == cause_servo_off && soff_r >= 4'h8
    |=> emerg_stop && err_clear) else $error("estop setting not decoded");
  a_power_free: assert property ( // RQ6
    state_r == st_decel && cause == cause_power && ploss_r == 4'h1 && soff_r == 4'h0
    |=> free_run && !dyn_brake) else $error("supply loss setting not used");
  a_uv_trip: assert property ( // RQ7
    power_alarm && uv_sel_r |=> undervoltage_alarm [*2]) else $error("undervoltage not tripped");
  a_uv_quiet: assert property ( // RQ7
    !uv_sel_r && !undervoltage_alarm |=> !undervoltage_alarm) else $error("undervoltage tripped");
  a_div_output: assert property ( // RQ9
    pw_on |=> encoder_divider_denominator == $past(div_r)) else $error("divider not applied");
  a_gear_pick: assert property ( // RQ10
    gear_sel_s == 2'h1 && (num_a_r | num_b_r | num_c_r) != 31'h0000_0000
    |=> gear_numerator == $past(num_b_r)) else $error("wrong gear numerator");
  a_gear_subst: assert property ( // RQ11
    (num_a_r | num_b_r | num_c_r) == 31'h0000_0000 |=> gear_numerator == ENC_RESOLUTION)
    else $error("encoder resolution not substituted");
  a_cfg_frozen: assert property ( // RQ12
    !pw_on |=> $stable(act_div_r) && $stable(act_tsel_r) && $stable(act_hold_r))
    else $error("frozen setting changed without power cycle");
endmodule
`default_nettype wire

//--- logic/sssel_consts.svh
/*
  Register offsets, field positions, reset values and timing counts of the
  servo stop-mode selection block.
  Assumes it is included by bare name from the logic/ folder.
*/
`ifndef SSSEL_CONSTS_SVH
`define SSSEL_CONSTS_SVH

// Register byte offsets
`define SSSEL_OFS_GEAR_NUM_A 8'h00
`define SSSEL_OFS_GEAR_NUM_B 8'h04
`define SSSEL_OFS_GEAR_NUM_C 8'h08
`define SSSEL_OFS_GEAR_DEN 8'h0C
`define SSSEL_OFS_ENC_DIV 8'h10
`define SSSEL_OFS_TRAVEL_SEL 8'h14
`define SSSEL_OFS_TRAVEL_STOP 8'h18
`define SSSEL_OFS_SERVO_OFF_STOP 8'h1C
`define SSSEL_OFS_PWR_LOSS_STOP 8'h20
`define SSSEL_OFS_UV_SELECT 8'h24
`define SSSEL_OFS_HOLD_TIME 8'h28
`define SSSEL_OFS_STATUS 8'h30
`define SSSEL_OFS_IRQ_STATUS 8'h34
`define SSSEL_OFS_IRQ_ENABLE 8'h38
`define SSSEL_OFS_IRQ_CLEAR 8'h3C
`define SSSEL_OFS_ACTIVE_CFG 8'h40
`define SSSEL_OFS_ACTIVE_DIV 8'h44

// Reset values
`define SSSEL_RST_GEAR_NUM 31'h0000_0000
`define SSSEL_RST_GEAR_DEN 31'h0000_0001
`define SSSEL_RST_ENC_DIV 19'h0_0000
`define SSSEL_RST_TRAVEL_SEL 2'h1
`define SSSEL_RST_TRAVEL_STOP 2'h0
`define SSSEL_RST_STOP_SEL 4'h0
`define SSSEL_RST_UV_SELECT 1'h1
`define SSSEL_RST_HOLD_TIME 11'h046

// Accepted write ranges, compared against the full data word
`define SSSEL_MAX_GEAR_NUM 32'h4000_0000
`define SSSEL_MAX_GEAR_DEN 32'h7FFF_FFFF
`define SSSEL_MAX_ENC_DIV 32'h0004_0000
`define SSSEL_MAX_TRAVEL 32'h0000_0002
`define SSSEL_MAX_STOP_SEL 32'h0000_0009
`define SSSEL_MAX_UV_SELECT 32'h0000_0001
`define SSSEL_MIN_HOLD_TIME 32'h0000_0046
`define SSSEL_MAX_HOLD_TIME 32'h0000_07D0

// Setting values and fields
`define SSSEL_TRAVEL_IGNORE 2'h1
`define SSSEL_TSTOP_FREE 2'h1
`define SSSEL_STOP_ESTOP_MIN 4'h8
`define SSSEL_STOP_FREE_BIT 0
`define SSSEL_STOP_SFREE_BIT 1
`define SSSEL_STOP_HOLD_BIT 2

// Interrupt status bits
`define SSSEL_IRQ_FWD 0
`define SSSEL_IRQ_REV 1
`define SSSEL_IRQ_PWR 2
`define SSSEL_IRQ_UV 3
`define SSSEL_IRQ_STOP 4
`define SSSEL_IRQ_W 5

// Timing: hold time step and clock period
`define SSSEL_HOLD_STEP_NS 1000000
`define SSSEL_CLK_PERIOD_NS 25

`endif

//--- logic/sssel_pkg.sv
/*
  Types of the servo stop-mode selection block.
  Assumes nothing of its surroundings.
*/
package sssel_pkg;
  typedef enum logic [1:0] {decel_dbrake, decel_free, decel_estop} sssel_decel_t;
  typedef enum logic {after_dbrake, after_free} sssel_after_t;
  typedef enum logic [1:0] {cause_none, cause_servo_off, cause_power} sssel_cause_t;
  typedef enum logic [1:0] {st_run, st_decel, st_stopped} sssel_state_t;
endpackage

//--- logic/sssel_stop_if.sv
/*
  Carrier between a stop setting and its decoded actions.
  Assumes one decoder and one user per instance.
*/
`timescale 1ns/100ps
`default_nettype none
interface sssel_stop_if import sssel_pkg::*; ();
  logic [3:0] setting;
  sssel_decel_t decel;
  sssel_after_t after;
  logic hold_count;
  modport dec (input setting, output decel, output after, output hold_count);
  modport user (output setting, input decel, input after, input hold_count);
endinterface
`default_nettype wire

//--- logic/sssel_stop_decode.sv
/*
  Decodes a 0 to 9 stop setting into deceleration, after-stop and counter actions.
  Assumes the setting never exceeds 9; the register write filter keeps it so.
*/
`timescale 1ns/100ps
`default_nettype none
`include "sssel_consts.svh"
module sssel_stop_decode import sssel_pkg::*; (
  sssel_stop_if.dec stop
);
  always_comb begin
    if (stop.setting >= `SSSEL_STOP_ESTOP_MIN) begin
      stop.decel = decel_estop; // RQ5
      stop.after = stop.setting[`SSSEL_STOP_FREE_BIT] ? after_free : after_dbrake; // RQ5
      stop.hold_count = 1'b0; // RQ5
    end else begin
      stop.decel = stop.setting[`SSSEL_STOP_FREE_BIT] ? decel_free : decel_dbrake; // RQ4
      stop.after = stop.setting[`SSSEL_STOP_SFREE_BIT] ? after_free : after_dbrake; // RQ4
      stop.hold_count = stop.setting[`SSSEL_STOP_HOLD_BIT]; // RQ4
    end
  end
endmodule
`default_nettype wire

//--- logic/sssel_hold_timer.sv
/*
  Momentary hold timer: declares the supply alarm once loss lasts the hold time.
  Assumes supply_lost is already synchronised to hclk.
*/
`timescale 1ns/100ps
`default_nettype none
`include "sssel_consts.svh"
module sssel_hold_timer import sssel_pkg::*; #(
  parameter int unsigned MS_CYCLES = `SSSEL_HOLD_STEP_NS / `SSSEL_CLK_PERIOD_NS,
  parameter int unsigned HOLD_W = 11
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic supply_lost,
  input wire logic [HOLD_W-1:0] hold_ms,
  output logic alarm
);
  localparam int unsigned PRE_W = $clog2(MS_CYCLES + 1);
  logic [PRE_W-1:0] pre_r, pre_nxt;
  logic [HOLD_W-1:0] ms_r, ms_nxt;
  logic alarm_r, alarm_nxt;

  always_comb begin
    pre_nxt = '0;
    ms_nxt = '0;
    alarm_nxt = 1'b0;
    if (supply_lost) begin
      alarm_nxt = alarm_r | (ms_r >= hold_ms); // RQ8
      if (pre_r == PRE_W'(MS_CYCLES - 1)) begin
        ms_nxt = (ms_r == '1) ? ms_r : ms_r + 1'b1;
      end else begin
        pre_nxt = pre_r + 1'b1;
        ms_nxt = ms_r;
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pre_r <= '0;
      ms_r <= '0;
      alarm_r <= 1'b0;
    end else begin
      pre_r <= pre_nxt;
      ms_r <= ms_nxt;
      alarm_r <= alarm_nxt;
    end
  end

  assign alarm = alarm_r;

  a_hold_not_early: assert property (@(posedge hclk) disable iff (!hresetn) // RQ8
    !alarm_r && ms_r < hold_ms |=> !alarm_r) else $error("supply alarm before hold time");
  a_hold_reached: assert property (@(posedge hclk) disable iff (!hresetn) // RQ8
    supply_lost && ms_r >= hold_ms |=> alarm_r) else $error("supply alarm missing");
endmodule
`default_nettype wire

//--- tb/sssel_motor_model.sv
/* Motor model: reaches standstill a set number of cycles after torque goes.
   Assumes servo_enable is the drive's registered run output. */
`timescale 1ns/100ps
`default_nettype none
module sssel_motor_model (
  input wire logic hclk,
  input wire logic servo_enable,
  input wire logic [3:0] delay,
  output logic motor_stopped
);
  logic [3:0] cnt = 4'h0;
  initial motor_stopped = 1'b0;
  always @(posedge hclk) begin
    if (servo_enable) begin
      cnt <= 4'h0;
      motor_stopped <= 1'b0;
    end else if (cnt >= delay) begin
      motor_stopped <= 1'b1;
    end else begin
      cnt <= cnt + 4'h1;
    end
  end
endmodule
`default_nettype wire

//--- tb/tb.sv
/* Testbench of the stop-mode block: bus tasks, pin stimulus, self checks.
   Assumes a shortened millisecond step and the motor model on the far side. */
`timescale 1ns/100ps
`default_nettype none
`include "sssel_consts.svh"
`define CHK(a, e) begin comparisons++; if ((a) !== (e)) begin mismatches++; \
  $display("ERROR %0t got %h exp %h", $time, a, e); end end
module tb;
  logic hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0, servo_on_in = 1'b0;
  logic fwd_inhibit_in = 1'b0, rev_inhibit_in = 1'b0, main_power_ok_in = 1'b0;
  logic [1:0] htrans = 2'h0, gear_select_in = 2'h0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] haddr = 32'h0000_0000, hwdata = 32'h0000_0000, q, r;
  logic [3:0] mdelay = 4'h8;
  wire logic hreadyout, hresp, motor_stopped_in, servo_enable, fwd_torque_off, rev_torque_off;
  wire logic dyn_brake, free_run, emerg_stop, servo_free, err_clear, err_hold;
  wire logic undervoltage_alarm, irq;
  wire logic [31:0] hrdata;
  wire logic [30:0] gear_numerator, gear_denominator;
  wire logic [18:0] encoder_divider_denominator;
  int comparisons = 0, mismatches = 0, cycles = 0;
  localparam logic [30:0] ENC = 31'h0000_1234;
  logic [7:0] ra [5] = '{`SSSEL_OFS_GEAR_DEN, `SSSEL_OFS_TRAVEL_SEL, `SSSEL_OFS_TRAVEL_STOP,
    `SSSEL_OFS_HOLD_TIME, 8'h50};
  logic [31:0] rv [5] = '{32'h0000_0001, 32'h0000_0001, 32'h0000_0000, 32'h0000_0046,
    32'h0000_0000};
  always #12.5 hclk = ~hclk;
  sssel_top #(.MS_CYCLES(4), .ENC_RESOLUTION(ENC)) sssel_top_inst (.hclk, .hresetn, .hsel,
    .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready(hreadyout), .hreadyout, .hresp,
    .hrdata, .fwd_inhibit_in, .rev_inhibit_in, .servo_on_in, .main_power_ok_in,
    .motor_stopped_in, .gear_select_in, .servo_enable, .fwd_torque_off, .rev_torque_off,
    .dyn_brake, .free_run, .emerg_stop, .servo_free, .err_clear, .err_hold,
    .undervoltage_alarm, .gear_numerator, .gear_denominator, .encoder_divider_denominator,
    .irq);
  sssel_motor_model sssel_motor_model_inst (.hclk, .servo_enable, .delay(mdelay),
    .motor_stopped(motor_stopped_in));
  task automatic tick(input int n);
    repeat (n) @(posedge hclk);
  endtask
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= {24'h00_0000, a};
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    q = hrdata;
    `CHK({hresp, hreadyout}, 2'h1)
  endtask
  // Decel actions as {brake, free-run, estop, clear, hold}
  function automatic logic [4:0] decel_exp(input logic [3:0] s);
    if (s >= 4'h8) return 5'h06;
    return {!s[0], s[0], 1'b0, !s[2], s[2]};
  endfunction
  function automatic logic after_free(input logic [3:0] s);
    return (s >= 4'h8) ? s[0] : s[1];
  endfunction
  task end_sim;
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  always @(posedge hclk) begin
    cycles++;
    if (cycles == 20000) begin
      mismatches++;
      end_sim;
    end
  end
  initial begin
    void'($urandom(32'hd67a_084f));
    tick(16);
    hresetn <= 1'b1;
    tick(1);
    foreach (ra[i]) begin
      bus(1'b0, ra[i], 32'h0000_0000);
      `CHK(q, rv[i])
    end
    bus(1'b0, `SSSEL_OFS_UV_SELECT, 32'h0000_0000);
    `CHK(q, 32'h0000_0001)
    main_power_ok_in <= 1'b1;
    servo_on_in <= 1'b1;
    fwd_inhibit_in <= 1'b1;
    tick(12);
    `CHK(fwd_torque_off, 1'b0)
    r = $urandom % 32'h0004_0001;
    bus(1'b1, `SSSEL_OFS_ENC_DIV, r);
    bus(1'b1, `SSSEL_OFS_TRAVEL_SEL, 32'h0000_0000);
    bus(1'b1, `SSSEL_OFS_TRAVEL_STOP, 32'h0000_0002);
    tick(6);
    `CHK({fwd_torque_off, encoder_divider_denominator}, 20'h0_0000)
    // Short supply dip: a power cycle that is too brief to raise the alarm
    main_power_ok_in <= 1'b0;
    tick(8);
    main_power_ok_in <= 1'b1;
    tick(12);
    `CHK(undervoltage_alarm, 1'b0)
    `CHK(encoder_divider_denominator, r[18:0])
    `CHK({fwd_torque_off, rev_torque_off, emerg_stop}, 3'h5)
    fwd_inhibit_in <= 1'b0;
    rev_inhibit_in <= 1'b1;
    tick(6);
    `CHK({fwd_torque_off, rev_torque_off}, 2'h1)
    rev_inhibit_in <= 1'b0;
    `CHK(gear_numerator, ENC)
    r = 32'h0000_0001 + $urandom % 32'h4000_0000;
    bus(1'b1, `SSSEL_OFS_GEAR_NUM_B, r);
    gear_select_in <= 2'h1;
    tick(6);
    `CHK({gear_numerator, gear_denominator}, {r[30:0], 31'h0000_0001})
    bus(1'b0, `SSSEL_OFS_IRQ_STATUS, 32'h0000_0000);
    `CHK(q, 32'h0000_0013)
    bus(1'b1, `SSSEL_OFS_IRQ_CLEAR, 32'h0000_001F);
    bus(1'b1, `SSSEL_OFS_IRQ_ENABLE, 32'h0000_0010);
    tick(2);
    `CHK(irq, 1'b0)
    for (int s = 0; s < 10; s++) begin
      bus(1'b1, `SSSEL_OFS_SERVO_OFF_STOP, s);
      mdelay <= 4'h8 + 4'($urandom % 8);
      servo_on_in <= 1'b0;
      tick(6);
      `CHK({dyn_brake, free_run, emerg_stop, err_clear, err_hold}, decel_exp(4'(s)))
      tick(40);
      `CHK({dyn_brake, servo_free, irq}, {!after_free(4'(s)), after_free(4'(s)), 1'b1})
      bus(1'b1, `SSSEL_OFS_IRQ_CLEAR, 32'h0000_0010);
      servo_on_in <= 1'b1;
      tick(12);
      `CHK(irq, 1'b0)
    end
    bus(1'b1, `SSSEL_OFS_PWR_LOSS_STOP, 32'h0000_0008);
    bus(1'b1, `SSSEL_OFS_IRQ_ENABLE, 32'h0000_0008);
    main_power_ok_in <= 1'b0;
    tick(270);
    `CHK(undervoltage_alarm, 1'b0)
    tick(20);
    `CHK({undervoltage_alarm, irq}, 2'h3)
    tick(40);
    `CHK({dyn_brake, servo_free}, 2'h2)
    // Mid-run reset, then a supply alarm that only turns the servo off
    hresetn <= 1'b0;
    tick(2);
    hresetn <= 1'b1;
    tick(1);
    bus(1'b1, `SSSEL_OFS_UV_SELECT, 32'h0000_0000);
    bus(1'b1, `SSSEL_OFS_PWR_LOSS_STOP, 32'h0000_0001);
    tick(264);
    `CHK(servo_enable, 1'b1)
    tick(16);
    `CHK({undervoltage_alarm, servo_enable, free_run, dyn_brake}, 4'h2)
    end_sim;
  end
endmodule
`default_nettype wire
